// File: logic/atm_buf2.sv
module atm_buf2 #(
   parameter int W = 9
) (
   input wire logic core_clk_in,
   input wire logic resetn_in,
   input wire logic in_valid_in,
   input wire logic [W-1:0] in_data_in,
   output logic in_ready_out,
   output logic out_valid_out,
   output logic [W-1:0] out_data_out,
   input wire logic out_ready_in
);

   initial begin
      if (W < 1) begin
         $error("atm_buf2: width must be positive");
      end
   end

   logic [1:0] cnt_q;
   logic [1:0] cnt_d;
   logic [W-1:0] e0_q;
   logic [W-1:0] e1_q;
   logic valid_q;
   wire push = in_valid_in && (cnt_q != 2'd2);
   wire pop = valid_q && out_ready_in;

   // occupancy and handshake terms
   assign cnt_d = cnt_q + {1'b0, push} - {1'b0, pop};
   assign in_ready_out = (cnt_q != 2'd2);
   assign out_valid_out = valid_q;
   assign out_data_out = e0_q;

   // entry 0 is the head, entry 1 the overflow slot
   always_ff @(posedge core_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         cnt_q <= 2'd0;
         valid_q <= 1'b0;
         e0_q <= '0;
         e1_q <= '0;
      end else begin
         cnt_q <= cnt_d;
         valid_q <= (cnt_d != 2'd0);
         if (pop && push) begin
            e0_q <= (cnt_q == 2'd1) ? in_data_in : e1_q;
            e1_q <= in_data_in;
         end else if (pop) begin
            e0_q <= e1_q;
         end else if (push) begin
            if (cnt_q == 2'd0) begin
               e0_q <= in_data_in;
            end else begin
               e1_q <= in_data_in;
            end
         end
      end
   end

endmodule

// File: logic/atm_cfg.svh
`ifndef ATM_CFG_SVH
`define ATM_CFG_SVH

// procedure byte values
`define ATM_PB_MORE 8'h61
`define ATM_PB_WLEN 8'h6c
// status words
`define ATM_SW_NORMAL 16'h9000
`define ATM_SW_ERR 16'h6f00
// status word classes that may carry data
`define ATM_SW1_WARN_A 8'h62
`define ATM_SW1_WARN_B 8'h63
`define ATM_SW1_APP_HI 4'h9
// header layout
`define ATM_HDR_LEN 3'd5
`define ATM_HDR_INS_IDX 3'd1
`define ATM_HDR_P3_IDX 3'd4
// full length coded by a zero length byte
`define ATM_LEN_FULL 9'h100
// default limits
`define ATM_IFSD_DEF 254
`define ATM_BUF_MAX_DEF 256

`endif

// File: logic/atm_mapper.sv
`include "atm_cfg.svh"

module atm_mapper
   import atm_pkg::*;
#(
   parameter int IFSD = `ATM_IFSD_DEF,
   parameter int BUF_MAX = `ATM_BUF_MAX_DEF
) (
   input wire logic core_clk_in,
   input wire logic resetn_in,
   input wire logic t1_mode_in,
   input wire logic rx_valid_in,
   input wire logic [7:0] rx_data_in,
   input wire logic rx_last_in,
   output logic rx_ready_out,
   output logic cmd_valid_out,
   output logic [7:0] cmd_data_out,
   output logic cmd_first_out,
   input wire logic cmd_ready_in,
   output logic dec_req_out,
   output logic dec_phase_out,
   output logic [7:0] dec_ins_out,
   output logic [7:0] dec_p3_out,
   input wire logic dec_valid_in,
   input wire logic [1:0] dec_case_in,
   input wire logic dec_ok_in,
   input wire logic [15:0] dec_sw_in,
   input wire logic [8:0] dec_avail_in,
   input wire logic rsp_valid_in,
   input wire logic [7:0] rsp_data_in,
   output logic rsp_ready_out,
   output logic tx_valid_out,
   output logic [7:0] tx_data_out,
   output logic tx_blk_end_out,
   input wire logic tx_ready_in
);

   initial begin
      if (IFSD < 1 || IFSD > 254) begin
         $error("atm_mapper: IFSD must lie in 1..254");
      end
      if (BUF_MAX < 1 || BUF_MAX > 256) begin
         $error("atm_mapper: BUF_MAX must lie in 1..256");
      end
   end

   localparam logic [8:0] BUF_MAX_L = 9'(BUF_MAX);
   localparam logic [7:0] IFSD_LAST = 8'(IFSD - 1);

   // length byte to byte count, zero meaning the full 256
   function automatic logic [8:0] len_of(input logic [7:0] b);
      len_of = (b == 8'h00) ? `ATM_LEN_FULL : {1'b0, b};
   endfunction

   atm_state_type state_q, state_d;
   logic [2:0] idx_q, idx_d;
   logic [8:0] cnt_q, cnt_d;
   logic [7:0] pb1_q, pb1_d, pb2_q, pb2_d, ins_q, p3_q;
   logic phase_q, phase_d, indir_q, indir_d, drop_q, drop_d;
   logic [7:0] blk_q;
   logic rx_ready_q, cmd_valid_q, cmd_first_q, rsp_ready_q, dec_req_q;
   logic [7:0] cmd_data_q;
   logic push_valid, buf_in_ready;
   logic [8:0] push_word;

   // handshakes taken this cycle
   wire rx_take = rx_valid_in && rx_ready_q;
   wire rsp_take = rsp_valid_in && rsp_ready_q;
   wire dec_take = dec_valid_in && dec_req_q;
   wire cmd_room = !cmd_valid_q || cmd_ready_in;

   // length comparisons for a case 2 header; zero Le with short data
   // reads as 256 and so falls into the too-long branch
   wire [8:0] le = len_of(p3_q);
   wire [8:0] avail = dec_avail_in;
   wire too_long = le > avail;
   wire exact = le == avail;
   wire too_big = avail > BUF_MAX_L;
   wire [8:0] remain = avail - le;
   wire [15:0] err_sw = (dec_sw_in == `ATM_SW_NORMAL) ? `ATM_SW_ERR
                                                       : dec_sw_in;
   wire [7:0] sw1 = dec_sw_in[15:8];
   wire sw_data_ok = (sw1 == `ATM_SW1_WARN_A) || (sw1 == `ATM_SW1_WARN_B)
                     || (sw1[7:4] == `ATM_SW1_APP_HI);
   wire is_c2 = dec_case_in == ATM_CASE2;
   wire is_c4 = dec_case_in == ATM_CASE4;
   wire is_cdata = dec_case_in[1];

   // bytes pushed toward the terminal
   wire emit_fix = (state_q == ATM_S_ACK) || (state_q == ATM_S_PB1)
                   || (state_q == ATM_S_PB2);
   wire emit_ok = emit_fix && buf_in_ready;
   wire blk_full = t1_mode_in && (blk_q == IFSD_LAST);
   assign push_valid = emit_fix || (rsp_take && !drop_q);
   assign push_word[7:0] = (state_q == ATM_S_ACK) ? ins_q :
                           (state_q == ATM_S_PB1) ? pb1_q :
                           (state_q == ATM_S_PB2) ? pb2_q : rsp_data_in;
   assign push_word[8] = (state_q == ATM_S_PB2) || blk_full;

   // sequencing of one command exchange
   always_comb begin
      state_d = state_q;
      idx_d = idx_q;
      cnt_d = cnt_q;
      pb1_d = pb1_q;
      pb2_d = pb2_q;
      phase_d = phase_q;
      indir_d = indir_q;
      drop_d = drop_q;
      unique case (state_q)
         ATM_S_HDR: begin
            if (rx_take) begin
               // a long T=1 command must not wrap back to the first index
               if (idx_q != 3'd7) begin
                  idx_d = idx_q + 3'd1;
               end
               if (t1_mode_in ? rx_last_in
                              : (idx_q == `ATM_HDR_LEN - 3'd1)) begin
                  state_d = ATM_S_DEC;
                  idx_d = 3'd0;
               end
            end
         end
         ATM_S_DEC: begin
            if (dec_take) begin
               state_d = ATM_S_PB1;
               {pb1_d, pb2_d} = dec_ok_in ? dec_sw_in : err_sw;
               if (t1_mode_in) begin
                  {pb1_d, pb2_d} = dec_sw_in;
                  cnt_d = avail;
                  drop_d = !sw_data_ok;
                  if (avail != 9'd0) begin
                     state_d = ATM_S_OUT;
                  end
               end else if (!dec_ok_in) begin
                  state_d = ATM_S_PB1;
               end else if (phase_q) begin
                  if (is_c4) begin
                     pb1_d = `ATM_PB_MORE;
                     pb2_d = avail[7:0];
                  end
               end else if (is_c2) begin
                  if (too_long) begin
                     pb1_d = `ATM_PB_WLEN;
                     pb2_d = avail[7:0];
                  end else if (exact && too_big) begin
                     pb1_d = `ATM_PB_MORE;
                     pb2_d = BUF_MAX_L[7:0];
                  end else begin
                     state_d = ATM_S_ACK;
                     indir_d = 1'b0;
                     cnt_d = le;
                     drop_d = 1'b0;
                     if (!exact) begin
                        pb1_d = `ATM_PB_MORE;
                        pb2_d = remain[7:0];
                     end
                  end
               end else if (is_cdata) begin
                  state_d = ATM_S_ACK;
                  indir_d = 1'b1;
                  cnt_d = le;
               end
            end
         end
         ATM_S_ACK: begin
            if (emit_ok) begin
               state_d = indir_q ? ATM_S_IN : ATM_S_OUT;
            end
         end
         ATM_S_IN: begin
            if (rx_take) begin
               cnt_d = cnt_q - 9'd1;
               if (cnt_q == 9'd1) begin
                  state_d = ATM_S_DEC;
                  phase_d = 1'b1;
               end
            end
         end
         ATM_S_OUT: begin
            if (rsp_take) begin
               cnt_d = cnt_q - 9'd1;
               if (cnt_q == 9'd1) begin
                  state_d = ATM_S_PB1;
               end
            end
         end
         ATM_S_PB1: begin
            if (emit_ok) begin
               state_d = ATM_S_PB2;
            end
         end
         ATM_S_PB2: begin
            if (emit_ok) begin
               state_d = ATM_S_HDR;
               phase_d = 1'b0;
               drop_d = 1'b0;
            end
         end
         default: begin
            state_d = ATM_S_HDR;
         end
      endcase
   end

   // state and exchange context
   always_ff @(posedge core_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         state_q <= ATM_S_HDR;
         idx_q <= 3'd0;
         cnt_q <= 9'd0;
         pb1_q <= 8'h00;
         pb2_q <= 8'h00;
         phase_q <= 1'b0;
         indir_q <= 1'b0;
         drop_q <= 1'b0;
      end else begin
         state_q <= state_d;
         idx_q <= idx_d;
         cnt_q <= cnt_d;
         pb1_q <= pb1_d;
         pb2_q <= pb2_d;
         phase_q <= phase_d;
         indir_q <= indir_d;
         drop_q <= drop_d;
      end
   end

   // header fields caught for the decision and the ack byte
   always_ff @(posedge core_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         ins_q <= 8'h00;
         p3_q <= 8'h00;
      end else if (rx_take && state_q == ATM_S_HDR && !t1_mode_in) begin
         if (idx_q == `ATM_HDR_INS_IDX) begin
            ins_q <= rx_data_in;
         end
         if (idx_q == `ATM_HDR_P3_IDX) begin
            p3_q <= rx_data_in;
         end
      end
   end

   // block byte count for chaining marks
   always_ff @(posedge core_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         blk_q <= 8'h00;
      end else if (push_valid && buf_in_ready) begin
         blk_q <= push_word[8] ? 8'h00 : blk_q + 8'h01;
      end
   end

   // handshake registers; a ready drops for one cycle after each take
   always_ff @(posedge core_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         rx_ready_q <= 1'b0;
         rsp_ready_q <= 1'b0;
         dec_req_q <= 1'b0;
         cmd_valid_q <= 1'b0;
         cmd_first_q <= 1'b0;
         cmd_data_q <= 8'h00;
      end else begin
         rx_ready_q <= (state_d == ATM_S_HDR || state_d == ATM_S_IN)
                       && !rx_take && cmd_room;
         // a push in flight may fill the buffer, so wait for its count
         rsp_ready_q <= (state_d == ATM_S_OUT) && !rsp_take
                        && !push_valid && buf_in_ready;
         dec_req_q <= (state_d == ATM_S_DEC) && !dec_take;
         if (rx_take) begin
            cmd_valid_q <= 1'b1;
            cmd_data_q <= rx_data_in;
            cmd_first_q <= (state_q == ATM_S_HDR) && (idx_q == 3'd0);
         end else if (cmd_ready_in) begin
            cmd_valid_q <= 1'b0;
         end
      end
   end

   assign rx_ready_out = rx_ready_q;
   assign rsp_ready_out = rsp_ready_q;
   assign dec_req_out = dec_req_q;
   assign dec_phase_out = phase_q;
   assign dec_ins_out = ins_q;
   assign dec_p3_out = p3_q;
   assign cmd_valid_out = cmd_valid_q;
   assign cmd_data_out = cmd_data_q;
   assign cmd_first_out = cmd_first_q;

   // two-entry buffer toward the terminal
   atm_buf2 #(
      .W(9)
   ) u_txbuf (
      .core_clk_in(core_clk_in),
      .resetn_in(resetn_in),
      .in_valid_in(push_valid),
      .in_data_in(push_word),
      .in_ready_out(buf_in_ready),
      .out_valid_out(tx_valid_out),
      .out_data_out({tx_blk_end_out, tx_data_out}),
      .out_ready_in(tx_ready_in)
   );

endmodule

// File: logic/atm_pkg.sv
package atm_pkg;

   // command case as classified by the application behind the mapper
   typedef enum logic [1:0] {
      ATM_CASE1 = 2'b00,
      ATM_CASE2 = 2'b01,
      ATM_CASE3 = 2'b10,
      ATM_CASE4 = 2'b11
   } atm_case_type;

   typedef enum logic [2:0] {
      ATM_S_HDR = 3'b000,
      ATM_S_DEC = 3'b001,
      ATM_S_ACK = 3'b010,
      ATM_S_IN = 3'b011,
      ATM_S_OUT = 3'b100,
      ATM_S_PB1 = 3'b101,
      ATM_S_PB2 = 3'b110
   } atm_state_type;

endpackage

// File: sim/apdu_transport_mapper_test.sv
`define CHK(a, b) \
   begin \
      check_count++; \
      if ((a) !== (b)) begin \
         err_count++; \
         $display("wrong value at %0t: %h not %h", $time, a, b); \
      end \
   end

module apdu_transport_mapper_test
   import atm_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int BM = 16;
   localparam int BI = 4;
   integer seed = 32'he08c;
   int err_count = 0;
   int check_count = 0;
   int tn = 0;
   logic core_clk_in = 1'b0;
   logic resetn_in = 1'b0;
   logic t1_mode_in = 1'b0;
   logic cmd_ready_in = 1'b0;
   logic dec_valid_in = 1'b0;
   logic dec_ok_in = 1'b0;
   logic [1:0] dec_case_in = 2'h0;
   logic [15:0] dec_sw_in = 16'h0000;
   logic [8:0] dec_avail_in = 9'h000;
   logic rsp_valid_in = 1'b0;
   logic [7:0] rsp_data_in = 8'h00;
   logic rx_valid_in, rx_last_in, rx_ready_out, cmd_valid_out, cmd_first_out;
   logic [7:0] rx_data_in, cmd_data_out, dec_ins_out, dec_p3_out, tx_data_out;
   logic dec_req_out, dec_phase_out, rsp_ready_out;
   logic tx_valid_out, tx_blk_end_out, tx_ready_in;
   logic [7:0] rq[$];
   logic [8:0] exp[$], cexp[$], cgot[$];

   atm_mapper #(.BUF_MAX(BM), .IFSD(BI)) atm_mapper_i (.*);

   atm_term_model atm_term_model_i (
      .core_clk_in, .rx_valid_out(rx_valid_in), .rx_data_out(rx_data_in),
      .rx_last_out(rx_last_in), .rx_ready_in(rx_ready_out),
      .tx_ready_out(tx_ready_in), .tx_valid_in(tx_valid_out),
      .tx_data_in(tx_data_out), .tx_blk_end_in(tx_blk_end_out));

   always #20 core_clk_in = ~core_clk_in;

   // application side: response source and command sink
   always @(posedge core_clk_in) begin
      if (rsp_valid_in && rsp_ready_out) void'(rq.pop_front());
      if (cmd_valid_out && cmd_ready_in) begin
         cgot.push_back({cmd_first_out, cmd_data_out});
      end
      rsp_valid_in <= rq.size() > 0;
      rsp_data_in <= rq.size() > 0 ? rq[0] : ~rsp_data_in;
      cmd_ready_in <= 1'($random(seed));
   end

   task automatic pair(input logic [15:0] w);
      exp.push_back({1'b0, w[15:8]});
      exp.push_back({1'b1, w[7:0]});
   endtask

   task automatic give(input logic [7:0] b[$], input logic first);
      foreach (b[i]) cexp.push_back({first && i == 0, b[i]});
      atm_term_model_i.send(b);
   endtask

   task automatic decide(input logic [1:0] cs, input logic ok,
         input logic [15:0] sw, input logic [8:0] av, input logic ph);
      do @(posedge core_clk_in); while (!dec_req_out);
      `CHK(dec_phase_out, ph)
      dec_valid_in <= 1'b1;
      dec_case_in <= cs;
      dec_ok_in <= ok;
      dec_sw_in <= sw;
      dec_avail_in <= av;
      @(posedge core_clk_in);
      dec_valid_in <= 1'b0;
   endtask

   // one exchange: header, decisions, then reply and command checks
   task automatic scen(input logic [1:0] cs, input logic [7:0] p3,
         input logic ok, input logic ok1, input logic [15:0] sw,
         input logic [8:0] av);
      logic [7:0] b[$];
      logic [8:0] le;
      logic [7:0] ins, d;
      int n;
      ins = 8'($random(seed));
      b = {8'($random(seed)), ins, 8'($random(seed)), 8'($random(seed)), p3};
      le = p3 == 8'h00 ? 9'h100 : {1'b0, p3};
      give(b, 1'b1);
      decide(cs, ok, sw, av, 1'b0);
      `CHK(dec_p3_out, p3)
      `CHK(dec_ins_out, ins)
      if (!ok) begin
         pair(sw == 16'h9000 ? 16'h6f00 : sw);
      end else if (cs == ATM_CASE4) begin
         exp.push_back({1'b0, ins});
         while (atm_term_model_i.got.size() < 1) @(posedge core_clk_in);
         b = {};
         repeat (p3) b.push_back(8'($random(seed)));
         give(b, 1'b0);
         decide(cs, ok1, sw, av, 1'b1);
         pair(ok1 ? {8'h61, av[7:0]} : sw);
      end else if (le > av) begin
         pair({8'h6c, av[7:0]});
      end else if (le == av && av > BM) begin
         pair({8'h61, 8'(BM)});
      end else begin
         exp.push_back({1'b0, ins});
         for (n = 0; n < le; n++) begin
            d = 8'($random(seed));
            rq.push_back(d);
            exp.push_back({1'b0, d});
         end
         pair(le == av ? sw : {8'h61, 8'(av - le)});
      end
      settle();
   endtask

   // waits for the whole reply, then compares it and the command copy
   task automatic settle();
      while (atm_term_model_i.got.size() < exp.size()) @(posedge core_clk_in);
      repeat (20) @(posedge core_clk_in);
      `CHK(atm_term_model_i.got.size(), exp.size())
      foreach (exp[i]) `CHK(atm_term_model_i.got[i], exp[i])
      `CHK(cgot.size(), cexp.size())
      foreach (cexp[i]) `CHK(cgot[i], cexp[i])
      exp = {};
      cexp = {};
      cgot = {};
      atm_term_model_i.got = {};
      tn++;
      $display("test %0d ended", tn);
   endtask

   // T=1 exchange: command passes whole, reply data kept or dropped
   task automatic scen1(input int nc, input logic [15:0] sw,
         input logic [8:0] av);
      logic [7:0] b[$];
      logic [7:0] d;
      logic keep;
      int k;
      keep = sw[15:8] == 8'h62 || sw[15:8] == 8'h63 || sw[15:12] == 4'h9;
      k = 0;
      repeat (nc) b.push_back(8'($random(seed)));
      give(b, 1'b1);
      decide(ATM_CASE4, 1'b1, sw, av, 1'b0);
      repeat (av) begin
         d = 8'($random(seed));
         rq.push_back(d);
         if (keep) begin
            exp.push_back({(k % BI) == (BI - 1), d});
            k++;
         end
      end
      exp.push_back({(k % BI) == (BI - 1), sw[15:8]});
      exp.push_back({1'b1, sw[7:0]});
      settle();
   endtask

   task automatic test_done();
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // watchdog against a hung handshake
   initial begin
      repeat (30000) @(posedge core_clk_in);
      err_count++;
      test_done();
   end

   // case 2 lengths around the available count, errors, case 4 flows
   initial begin
      repeat (10) @(posedge core_clk_in);
      resetn_in <= 1'b1;
      scen(ATM_CASE2, 8'd5, 1'b1, 1'b1, 16'h9000, 9'd3);
      scen(ATM_CASE2, 8'd3, 1'b1, 1'b1, 16'h9000, 9'd3);
      scen(ATM_CASE2, 8'd0, 1'b1, 1'b1, 16'h9000, 9'd7);
      scen(ATM_CASE2, 8'd0, 1'b1, 1'b1, 16'h9000, 9'h100);
      scen(ATM_CASE2, 8'd16, 1'b1, 1'b1, 16'h9000, 9'd16);
      scen(ATM_CASE2, 8'd17, 1'b1, 1'b1, 16'h9000, 9'd17);
      scen(ATM_CASE2, 8'd2, 1'b1, 1'b1, 16'h9000, 9'd5);
      scen(ATM_CASE2, 8'd4, 1'b0, 1'b1, 16'h9000, 9'd4);
      scen(ATM_CASE2, 8'd4, 1'b0, 1'b1, 16'h6a82, 9'd4);
      scen(ATM_CASE4, 8'd4, 1'b1, 1'b1, 16'h9000, 9'd9);
      scen(ATM_CASE2, 8'd9, 1'b1, 1'b1, 16'h9000, 9'd9);
      scen(ATM_CASE4, 8'd3, 1'b1, 1'b0, 16'h6283, 9'd5);
      scen(ATM_CASE2, 8'd0, 1'b1, 1'b1, 16'h6283, 9'd5);
      scen(ATM_CASE2, 8'd5, 1'b1, 1'b1, 16'h6283, 9'd5);
      scen(ATM_CASE4, 8'd2, 1'b1, 1'b0, 16'h6a80, 9'd5);
      scen(ATM_CASE4, 8'd2, 1'b0, 1'b1, 16'h6d00, 9'd5);
      t1_mode_in <= 1'b1;
      scen1(10, 16'h9000, 9'd9);
      scen1(5, 16'h6a82, 9'd6);
      scen1(3, 16'h6283, 9'd3);
      test_done();
   end
endmodule

// File: sim/atm_mapper_checker.sv
module atm_mapper_checker
   import atm_pkg::*;
#(
   parameter int BUF_MAX = 256
) (
   input wire logic core_clk_in,
   input wire logic resetn_in,
   input wire logic t1_mode_in,
   input wire logic rx_valid_in,
   input wire logic [7:0] rx_data_in,
   input wire logic rx_ready_out,
   input wire logic cmd_valid_out,
   input wire logic [7:0] cmd_data_out,
   input wire logic dec_req_out,
   input wire logic dec_phase_out,
   input wire logic [7:0] dec_ins_out,
   input wire logic [7:0] dec_p3_out,
   input wire logic dec_valid_in,
   input wire logic [1:0] dec_case_in,
   input wire logic dec_ok_in,
   input wire logic [15:0] dec_sw_in,
   input wire logic [8:0] dec_avail_in,
   input wire logic tx_valid_out,
   input wire logic [7:0] tx_data_out,
   input wire logic tx_blk_end_out,
   input wire logic tx_ready_in
);
   // decision taken, asked length (zero means full) and case 2 normal
   wire take = dec_valid_in && dec_req_out;
   wire [8:0] le = {dec_p3_out == 8'h00, dec_p3_out};
   wire c2 = take && !t1_mode_in && dec_ok_in && dec_case_in == ATM_CASE2;
   wire c4 = take && !t1_mode_in && dec_ok_in && dec_case_in == ATM_CASE4;
   logic [7:0] sw1_q;

   default clocking @(posedge core_clk_in); endclocking
   default disable iff (!resetn_in);

   // first status byte due after a refused decision
   always_ff @(posedge core_clk_in or negedge resetn_in) begin
      if (!resetn_in) sw1_q <= 8'h00;
      else if (take) sw1_q <= dec_sw_in == 16'h9000 ? 8'h6f : dec_sw_in[15:8];
   end

   AST_WLEN: assert property (
      c2 && le > dec_avail_in
      |-> ##[1:6] (tx_valid_out && tx_data_out == 8'h6c))
      else $error("wrong-length byte missing");
   AST_EXACT: assert property (
      c2 && le == dec_avail_in && dec_avail_in <= BUF_MAX
      |-> ##[1:6] (tx_valid_out && tx_data_out == dec_ins_out))
      else $error("exact length not sent under control byte");
   AST_BUFCAP: assert property (
      c2 && le == dec_avail_in && dec_avail_in > BUF_MAX
      |-> ##[1:6] (tx_valid_out && tx_data_out == 8'h61))
      else $error("short buffer did not ask for fetch");
   AST_SHORT: assert property (
      c2 && le < dec_avail_in
      |-> ##[1:6] (tx_valid_out && tx_data_out == dec_ins_out))
      else $error("short length not sent under control byte");
   AST_MORE: assert property (
      c4 && dec_phase_out |-> ##[1:6] (tx_valid_out && tx_data_out == 8'h61))
      else $error("case 4 result did not ask for fetch");
   AST_ERR: assert property (
      take && !dec_ok_in && !t1_mode_in
      |-> ##[1:6] (tx_valid_out && tx_data_out == sw1_q))
      else $error("refused command did not return status");
   AST_CMD_COPY: assert property (
      rx_valid_in && rx_ready_out
      |=> (cmd_valid_out && cmd_data_out == $past(rx_data_in)))
      else $error("command byte not passed on");
   AST_TX_HOLD: assert property (
      tx_valid_out && !tx_ready_in |=> (tx_valid_out
      && $stable(tx_data_out) && $stable(tx_blk_end_out)))
      else $error("stalled reply byte changed");
endmodule

bind atm_mapper atm_mapper_checker #(.BUF_MAX(BUF_MAX)) chk_i (
   .core_clk_in, .resetn_in, .t1_mode_in, .rx_valid_in, .rx_data_in,
   .rx_ready_out, .cmd_valid_out, .cmd_data_out, .dec_req_out,
   .dec_phase_out, .dec_ins_out, .dec_p3_out, .dec_valid_in, .dec_case_in,
   .dec_ok_in, .dec_sw_in, .dec_avail_in, .tx_valid_out, .tx_data_out,
   .tx_blk_end_out, .tx_ready_in
);

// File: sim/atm_term_model.sv
module atm_term_model (
   input wire logic core_clk_in,
   output logic rx_valid_out = 1'b0,
   output logic [7:0] rx_data_out = 8'h00,
   output logic rx_last_out = 1'b0,
   input wire logic rx_ready_in,
   output logic tx_ready_out = 1'b0,
   input wire logic tx_valid_in,
   input wire logic [7:0] tx_data_in,
   input wire logic tx_blk_end_in
);
   timeunit 1ns;
   timeprecision 1ns;
   integer seed = 32'he08c;
   logic [8:0] got[$];

   // collects reply bytes with the end flag, stalling at random
   always @(posedge core_clk_in) begin
      if (tx_valid_in && tx_ready_out) begin
         got.push_back({tx_blk_end_in, tx_data_in});
      end
      tx_ready_out <= 1'($random(seed));
   end

   // offers bytes one by one, each held until taken
   task automatic send(input logic [7:0] b[$]);
      foreach (b[i]) begin
         @(posedge core_clk_in);
         rx_valid_out <= 1'b1;
         rx_data_out <= b[i];
         rx_last_out <= (i == b.size() - 1); // end mark on the last byte
         do @(posedge core_clk_in); while (!rx_ready_in);
         rx_valid_out <= 1'b0;
         rx_last_out <= 1'b0;
         rx_data_out <= ~b[i]; // released line shows no stale byte
      end
   endtask
endmodule
